// ---- hw/perf_event_counters_consts.vh ----
// Constants of the performance-event counter unit
`ifndef PERF_EVENT_COUNTERS_CONSTS_VH
`define PERF_EVENT_COUNTERS_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_RETIRED_INSTR     10'h309
`define IDX_CORE_CYCLES       10'h30a
`define IDX_REFERENCE_CYCLES  10'h30b
`define IDX_GP_COUNT0         10'h0c1
`define IDX_GP_COUNT1         10'h0c2
`define IDX_GP_SELECT0        10'h186
`define IDX_GP_SELECT1        10'h187

// Address bit that picks the upper 32 bits of a 64-bit counter
`define ADDR_HI_BIT           12
`define ADDR_TOP_LSB          13

// Reset values
`define COUNT_RESET           64'h0000_0000_0000_0000
`define SELECT_RESET          32'h0000_0000

// Event select register layout
`define SEL_EVENT_LSB         0
`define SEL_EVENT_MSB         7
`define SEL_UMASK_LSB         8
`define SEL_UMASK_MSB         15
`define SEL_ENABLE_BIT        22

// General-purpose event encodings
`define EVT_LOAD_BLOCK        8'h03
`define UMASK_STORE_ADDRESS   8'h02
`define UMASK_STORE_DATA      8'h04
`define UMASK_OVERLAP_STORE   8'h08
`define EVT_INST_RETIRED      8'hc0
`define UMASK_HOST_MODE       8'h08
`define EVT_RENAME_STALLS     8'hd2
`define UMASK_OTHER_SERIALIZE 8'h10

// Load data size codes
`define LOAD_SIZE_1           2'h0
`define LOAD_SIZE_2           2'h1
`define LOAD_SIZE_4           2'h2
`define LOAD_SIZE_8           2'h3

// AXI responses
`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

`endif

// ---- hw/perf_event_counters.v ----
// Performance-event counters with an AXI4-Lite register slave
`timescale 1ns/1ps
`include "perf_event_counters_consts.vh"

module perf_event_counters (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire        awvalid,
    output reg         awready,
    input  wire [15:0] awaddr,
    input  wire [2:0]  awprot,
    // AXI4-Lite write data
    input  wire        wvalid,
    output reg         wready,
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    // AXI4-Lite write response
    output reg         bvalid,
    input  wire        bready,
    output reg  [1:0]  bresp,
    // AXI4-Lite read address
    input  wire        arvalid,
    output reg         arready,
    input  wire [15:0] araddr,
    input  wire [2:0]  arprot,
    // AXI4-Lite read data
    output reg         rvalid,
    input  wire        rready,
    output reg  [31:0] rdata,
    output reg  [1:0]  rresp,
    // Retirement from the pipeline
    input  wire        uop_retire,
    input  wire        uop_last,
    input  wire        virtualization_host_mode,
    // Halt and clock-stop state
    input  wire        halt_instruction,
    input  wire        monitor_wait_instruction,
    input  wire        thermal_monitor_stopclock,
    // Time-stamp rate tick, also the bus-clock tick
    input  wire        ref_tick,
    // Load/store conflicts
    input  wire        load_wait_store_address,
    input  wire        load_wait_store_data,
    input  wire        overlap_partial,
    input  wire        overlap_covered,
    input  wire        store_size_aligned,
    input  wire [1:0]  load_size,
    input  wire        load_off_store_start,
    input  wire        load_misaligned,
    // Rename stage
    input  wire        rename_other_serialize_stall
);

    localparam NUM_COUNT = 5;
    localparam SLOT_NONE = 3'h7;

    // Counters 0..2 fixed, 3..4 general purpose; each slot owns its
    // register and this array is only the read view of them
    wire [63:0] count [0:NUM_COUNT-1];
    reg  [31:0] select0;
    reg  [31:0] select1;

    // Held write request
    reg         aw_held;
    reg         w_held;
    reg  [15:0] awaddr_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;

    wire [3:0]  wr_dec;
    wire [3:0]  rd_dec;
    wire        do_write;
    wire [NUM_COUNT-1:0] inc;
    wire        instr_retired;
    wire        overlap_store;
    wire        gp_event0;
    wire        gp_event1;
    wire        host_retired;
    wire        wr_refused;
    wire        rd_refused;
    reg  [31:0] next_rdata;

    // Address to {upper half, slot}; slot 5/6 are the event selects
    function [3:0] decode;
        input [15:0] a;
        reg   [2:0]  slot;
        begin
            slot = SLOT_NONE;
            if (a[15:`ADDR_TOP_LSB] == 3'h0 && a[1:0] == 2'h0) begin
                case (a[11:2])
                    `IDX_RETIRED_INSTR:    slot = 3'h0;
                    `IDX_CORE_CYCLES:      slot = 3'h1;
                    `IDX_REFERENCE_CYCLES: slot = 3'h2;
                    `IDX_GP_COUNT0:        slot = 3'h3;
                    `IDX_GP_COUNT1:        slot = 3'h4;
                    `IDX_GP_SELECT0:       slot = 3'h5;
                    `IDX_GP_SELECT1:       slot = 3'h6;
                    default:               slot = SLOT_NONE;
                endcase
            end
            // Selects have no upper half
            if (a[`ADDR_HI_BIT] && (slot == 3'h5 || slot == 3'h6))
                slot = SLOT_NONE;
            decode = {a[`ADDR_HI_BIT], slot};
        end
    endfunction

    // Byte-lane merge of a write into a stored word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        integer      b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b])
                    merge[8*b +: 8] = data[8*b +: 8];
            end
        end
    endfunction

    // General-purpose event match for one select register
    function gp_match;
        input [31:0] sel;
        input        ev_sta;
        input        ev_std;
        input        ev_ovl;
        input        ev_host;
        input        ev_stall;
        reg   [7:0]  evt;
        reg   [7:0]  um;
        begin
            evt = sel[`SEL_EVENT_MSB:`SEL_EVENT_LSB];
            um  = sel[`SEL_UMASK_MSB:`SEL_UMASK_LSB];
            // Unknown event and mask pairs count nothing
            gp_match = 1'b0;
            if (sel[`SEL_ENABLE_BIT]) begin
                if (evt == `EVT_LOAD_BLOCK && um == `UMASK_STORE_ADDRESS)
                    gp_match = ev_sta;
                if (evt == `EVT_LOAD_BLOCK && um == `UMASK_STORE_DATA)
                    gp_match = ev_std;
                if (evt == `EVT_LOAD_BLOCK && um == `UMASK_OVERLAP_STORE)
                    gp_match = ev_ovl;
                if (evt == `EVT_INST_RETIRED && um == `UMASK_HOST_MODE)
                    gp_match = ev_host;
                if (evt == `EVT_RENAME_STALLS && um == `UMASK_OTHER_SERIALIZE)
                    gp_match = ev_stall;
            end
        end
    endfunction

    // no gating by interrupt or handler state
    assign instr_retired = uop_retire & uop_last;

    // aligned store, small or misaligned load
    assign overlap_store = overlap_partial
        | (overlap_covered & store_size_aligned
           & ((((load_size == `LOAD_SIZE_1) | (load_size == `LOAD_SIZE_2))
               & load_off_store_start)
              | (((load_size == `LOAD_SIZE_4) | (load_size == `LOAD_SIZE_8))
               & load_misaligned)));

    // retirements seen while in host mode
    assign host_retired = instr_retired & virtualization_host_mode;

    // A blocked load counts every cycle it waits, so may add several
    assign gp_event0 = gp_match(select0, load_wait_store_address,
                                load_wait_store_data, overlap_store,
                                host_retired,
                                rename_other_serialize_stall);
    assign gp_event1 = gp_match(select1, load_wait_store_address,
                                load_wait_store_data, overlap_store,
                                host_retired,
                                rename_other_serialize_stall);

    assign inc[0] = instr_retired;
    // aclk is the core clock itself
    assign inc[1] = ~halt_instruction;
    assign inc[2] = ref_tick & ~halt_instruction & ~monitor_wait_instruction
                    & ~thermal_monitor_stopclock;
    // general events reach only counters 3 and 4
    assign inc[3] = gp_event0;
    assign inc[4] = gp_event1;

    // A write lands only once address and data are both held
    assign do_write = aw_held & w_held & ~bvalid;
    assign wr_dec   = decode(awaddr_q);
    assign rd_dec   = decode(araddr);

    // Refused accesses store nothing and answer with an error
    assign wr_refused = (wr_dec[2:0] == SLOT_NONE);
    assign rd_refused = (rd_dec[2:0] == SLOT_NONE);

    // Write channel; address and data are taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready  <= 1'b1;
            wready   <= 1'b1;
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            awaddr_q <= 16'h0000;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            bvalid   <= 1'b0;
            bresp    <= `RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awready  <= 1'b0;
                aw_held  <= 1'b1;
                awaddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wready  <= 1'b0;
                w_held  <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= wr_refused ? `RESP_SLVERR : `RESP_OKAY;
            end
            // Ready again only after the response, so one write at a time
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Counters; a software load wins over a same-cycle increment,
    // and that increment is lost rather than deferred
    genvar i;
    generate
        for (i = 0; i < NUM_COUNT; i = i + 1) begin : g_count
            wire wr_lo = do_write & (wr_dec[2:0] == i) & ~wr_dec[3];
            wire wr_hi = do_write & (wr_dec[2:0] == i) & wr_dec[3];
            reg  [63:0] value;
            always @(posedge aclk) begin
                if (!aresetn) begin
                    value <= `COUNT_RESET;
                end else if (wr_lo) begin
                    value[31:0] <= merge(value[31:0], wdata_q, wstrb_q);
                end else if (wr_hi) begin
                    value[63:32] <= merge(value[63:32], wdata_q, wstrb_q);
                end else if (inc[i]) begin
                    value <= value + 64'h1;
                end
            end
            assign count[i] = value;
        end
    endgenerate

    // Event select registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            select0 <= `SELECT_RESET;
            select1 <= `SELECT_RESET;
        end else if (do_write) begin
            if (wr_dec[2:0] == 3'h5)
                select0 <= merge(select0, wdata_q, wstrb_q);
            if (wr_dec[2:0] == 3'h6)
                select1 <= merge(select1, wdata_q, wstrb_q);
        end
    end

    // Read data mux; the two halves of a counter are read apart, so a
    // carry may fall between them
    always @* begin
        next_rdata = 32'h0000_0000;
        case (rd_dec[2:0])
            3'h0, 3'h1, 3'h2, 3'h3, 3'h4:
                next_rdata = rd_dec[3] ? count[rd_dec[2:0]][63:32]
                                       : count[rd_dec[2:0]][31:0];
            3'h5:    next_rdata = select0;
            3'h6:    next_rdata = select1;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Read channel; answer one cycle after the address is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= next_rdata;
                rresp   <= rd_refused ? `RESP_SLVERR : `RESP_OKAY;
            end
            if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

endmodule // perf_event_counters

// ---- sim/pec_props.sv ----
// Bus-protocol checker bound to the performance counter unit
`timescale 1ns/1ps
module pec_props (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Write channels
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    // Read channels
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [15:0] araddr,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    rst_val_a: assert property ($rose(aresetn) |-> awready && wready && arready
        && !bvalid && !rvalid) else $error("bus outputs not idle after reset");
    ar_take_a: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read answer not one cycle after address");
    r_busy_a: assert property (rvalid |-> !arready)
        else $error("read address accepted during answer");
    r_done_a: assert property (rvalid && rready |=> !rvalid && arready)
        else $error("read channel not released");
    b_time_a: assert property (awvalid && awready && wvalid && wready
        |=> !bvalid ##1 bvalid) else $error("write response timing wrong");
    b_busy_a: assert property (bvalid |-> !awready && !wready)
        else $error("write accepted during response");
    b_done_a: assert property (bvalid && bready |=> !bvalid && awready && wready)
        else $error("write channel not released");
    bad_rd_a: assert property (arvalid && arready && araddr == 16'h0000
        |=> rresp == 2'h2 && rdata == 32'h0) else $error("unmapped read not refused");
    ok_rd_a: assert property (arvalid && arready && araddr == 16'h0c24
        |=> rresp == 2'h0) else $error("counter read refused");
endmodule // pec_props

// ---- sim/core_pipe_model.sv ----
// Core pipeline model driving retirement, halt and stall indications
`timescale 1ns/1ps
module core_pipe_model (
    // Clock and bench command
    input  wire logic        aclk,
    input  wire logic [16:0] cmd,
    // Pipeline indications, one bit each except the two-bit load size
    output logic      [16:0] core_sig
);
    always @(posedge aclk) begin
        core_sig <= cmd;
    end
endmodule // core_pipe_model

// ---- sim/perf_event_counters_tb_top.sv ----
// Self-checking bench for the performance counter unit
`timescale 1ns/1ps
module perf_event_counters_tb_top;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0;
    logic        bready = 0, arvalid = 0, rready = 0;
    logic [15:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [3:0]  strb = 4'hf;
    logic [16:0] cmd = 17'h8, base = 17'h8, sig;
    int          n_errors = 0, comparisons = 0;

    perf_event_counters dut_u (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(strb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .uop_retire(sig[0]), .uop_last(sig[1]), .virtualization_host_mode(sig[2]),
        .halt_instruction(sig[3]), .monitor_wait_instruction(sig[4]),
        .thermal_monitor_stopclock(sig[5]), .ref_tick(sig[6]),
        .load_wait_store_address(sig[7]), .load_wait_store_data(sig[8]),
        .overlap_partial(sig[9]), .overlap_covered(sig[10]),
        .store_size_aligned(sig[11]), .load_size(sig[13:12]),
        .load_off_store_start(sig[14]), .load_misaligned(sig[15]),
        .rename_other_serialize_stall(sig[16]));
    core_pipe_model core_u (.aclk(aclk), .cmd(cmd), .core_sig(sig));

    initial begin
        forever #2.5 aclk = ~aclk;
    end

    task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (!(awvalid && awready) && awvalid || !(wvalid && wready) && wvalid);
        while (bvalid !== 1'b1) @(posedge aclk);
        rs = bresp;
        bready <= 0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        v = rdata;
        rs = rresp;
        rready <= 0;
    endtask

    // Drive pipeline levels for k cycles; the model adds one cycle of delay
    task automatic hold(input logic [16:0] m, input int k);
        @(posedge aclk);
        cmd <= m;
        repeat (k) @(posedge aclk);
        cmd <= base;
        repeat (3) @(posedge aclk);
    endtask

    task automatic gp_case(input logic [15:0] s, input logic [16:0] m, input logic [31:0] e);
        wr(16'h0618, {16'h0040, s}, r);
        wr(16'h0304, 32'h0, r);
        hold(m, 4);
        rd(16'h0304, d, r);
        chk_data(d, e);
    endtask

    task automatic finish_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge aclk);
        n_errors++;
        finish_test;
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        rd(16'h0c24, d, r);
        chk_data(d, 32'h0);
        hold(17'h1, 5);
        hold(17'h3, 7);
        rd(16'h0c24, d, r);
        chk_data(d, 32'h7);
        wr(16'h0c28, 32'h0, r);
        chk_resp(r, 2'h0);
        hold(17'h8, 6);
        hold(17'h0, 9);
        rd(16'h0c28, d, r);
        chk_data(d, 32'h9);
        hold(17'h48, 4);
        hold(17'h50, 4);
        hold(17'h60, 4);
        rd(16'h0c2c, d, r);
        chk_data(d, 32'h0);
        hold(17'h40, 4);
        rd(16'h0c2c, d, r);
        chk_data(d, 32'h4);
        wr(16'h1c2c, 32'hffffffff, r);
        wr(16'h0c2c, 32'hfffffffe, r);
        hold(17'h40, 3);
        rd(16'h0c2c, d, r);
        chk_data(d, 32'h1);
        rd(16'h1c2c, d, r);
        chk_data(d, 32'h0);
        gp_case(16'h0203, 17'h00080, 32'h4);
        gp_case(16'h0403, 17'h00100, 32'h4);
        gp_case(16'h0803, 17'h00200, 32'h4);
        gp_case(16'h0803, 17'h04c00, 32'h4);
        gp_case(16'h0803, 17'h0ac00, 32'h4);
        gp_case(16'h0803, 17'h00c00, 32'h0);
        gp_case(16'h08c0, 17'h00007, 32'h4);
        gp_case(16'h08c0, 17'h00003, 32'h0);
        gp_case(16'h10d2, 17'h10000, 32'h4);
        wr(16'h061c, 32'h0040_0203, r);
        wr(16'h0308, 32'h0, r);
        hold(17'h00080, 4);
        rd(16'h0308, d, r);
        chk_data(d, 32'h4);
        rd(16'h0304, d, r);
        chk_data(d, 32'h4);
        strb <= 4'h2;
        wr(16'h0308, 32'h0000_ab00, r);
        strb <= 4'hf;
        rd(16'h0308, d, r);
        chk_data(d, 32'h0000_ab04);
        rd(16'h0c25, d, r);
        chk_resp(r, 2'h2);
        wr(16'h1618, 32'h0, r);
        chk_resp(r, 2'h2);
        rd(16'h0000, d, r);
        chk_resp(r, 2'h2);
        chk_data(d, 32'h0);
        wr(16'h0000, 32'h5, r);
        chk_resp(r, 2'h2);
        finish_test;
    end
endmodule // perf_event_counters_tb_top

bind perf_event_counters pec_props chk_u (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
